// [core/sso_status_outputs.sv]
// status indicators, routing and code outputs of a servo amplifier
//
// Overview of operation
// - running active while speed exceeds detection level
// - detection level 1 to 10000 rpm, default 20
// - running also shown on status and monitor
// - first selection routes running and ready, 3211
// - ready needs no alarm and main power on
// - absolute encoder adds sense high, data sent
// - ready means servo-on may now be accepted
// - warning active on overload or regen overload
// - warning route field 0 none, 1..3 pairs
// - terminals shared by indicators are ORed
// - code select 0 alarms only, 1 adds warnings
// - overload first code, regen second, third inactive
`timescale 1ns/1ps
`default_nettype none
module sso_status_outputs
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic [15:0] MOTOR_SPEED,
    input wire logic ALARM_PRESENT,
    input wire logic [2:0] ALARM_CODE,
    input wire logic MAIN_POWER_ON,
    input wire logic ABS_ENCODER_FITTED,
    input wire logic ABS_DATA_SENT,
    input wire logic ENCODER_SENSE_INPUT,
    input wire logic OVERLOAD_WARN,
    input wire logic REGEN_WARN,
    output logic [2:0] TERM_N,
    output logic [2:0] CODE_N,
    output logic STATUS_DISP_RUNNING,
    output logic SPEED_MON_RUNNING,
    output logic IRQ
);
    ////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [13:0] rot_level_reg;
    logic [15:0] osel_first_reg;
    logic [15:0] osel_second_reg;
    logic code_sel_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_stat_next;
    logic [2:0] irq_mask_reg;
    logic [13:0] wr_level;
    logic wr_level_ok;

    assign wr_level = WDATA[13:0];
    // out-of-range levels are ignored, the old level stays
    assign wr_level_ok = (WDATA[31:14] == 18'h0)
        && (wr_level >= sso_pkg::ROT_LEVEL_MIN)
        && (wr_level <= sso_pkg::ROT_LEVEL_MAX);

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            rot_level_reg <= sso_pkg::ROT_LEVEL_RST;
        end
        else if (CE && WR && ADDR == sso_pkg::OFS_ROT_LEVEL && wr_level_ok)
        begin
            rot_level_reg <= wr_level;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            osel_first_reg <= sso_pkg::OSEL_FIRST_RST;
            osel_second_reg <= sso_pkg::OSEL_SECOND_RST;
            code_sel_reg <= sso_pkg::CODE_SEL_RST;
            irq_mask_reg <= sso_pkg::IRQ_MASK_RST;
        end
        else if (CE && WR)
        begin
            case (ADDR)
                sso_pkg::OFS_OSEL_FIRST: osel_first_reg <= WDATA[15:0];
                sso_pkg::OFS_OSEL_SECOND: osel_second_reg <= WDATA[15:0];
                sso_pkg::OFS_CODE_SEL: code_sel_reg <= WDATA[0];
                sso_pkg::OFS_IRQ_MASK: irq_mask_reg <= WDATA[2:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // encoder sense pin synchroniser
    logic sense_meta_reg;
    logic sense_sync_reg;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            sense_meta_reg <= 1'b0;
            sense_sync_reg <= 1'b0;
        end
        else if (CE)
        begin
            sense_meta_reg <= ENCODER_SENSE_INPUT;
            sense_sync_reg <= sense_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // indicator flags, active high inside the block
    logic running_reg;
    logic ready_reg;
    logic warn_reg;
    logic above_level;
    logic below_level;
    logic ready_cond;
    logic warn_cond;

    assign above_level = MOTOR_SPEED > {2'h0, rot_level_reg};
    assign below_level = MOTOR_SPEED < {2'h0, rot_level_reg};
    // an absolute encoder also needs the host's sense level and data sent
    assign ready_cond = !ALARM_PRESENT && MAIN_POWER_ON
        && (!ABS_ENCODER_FITTED || (sense_sync_reg && ABS_DATA_SENT));
    assign warn_cond = OVERLOAD_WARN || REGEN_WARN;

    // at exactly the level the flag keeps its last state
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            running_reg <= 1'b0;
        end
        else if (CE)
        begin
            if (above_level)
            begin
                running_reg <= 1'b1;
            end
            else if (below_level)
            begin
                running_reg <= 1'b0;
            end
        end
    end

    // ready tells the host that a servo-on request is now accepted
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            ready_reg <= 1'b0;
        end
        else if (CE)
        begin
            ready_reg <= ready_cond;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            warn_reg <= 1'b0;
        end
        else if (CE)
        begin
            warn_reg <= warn_cond;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // terminal routing
    logic [2:0] run_hit;
    logic [2:0] rdy_hit;
    logic [2:0] warn_hit;
    logic [2:0] term_flags;
    logic [3:0] run_sel;
    logic [3:0] rdy_sel;
    logic [3:0] warn_sel;

    assign run_sel = osel_first_reg[sso_pkg::RUN_SEL_LSB +: sso_pkg::SEL_W];
    assign rdy_sel = osel_first_reg[sso_pkg::RDY_SEL_LSB +: sso_pkg::SEL_W];
    assign warn_sel =
        osel_second_reg[sso_pkg::WARN_SEL_LSB +: sso_pkg::SEL_W];

    sso_route u_run_route
    (
        .sel(run_sel),
        .flag(running_reg),
        .hit(run_hit)
    );

    sso_route u_rdy_route
    (
        .sel(rdy_sel),
        .flag(ready_reg),
        .hit(rdy_hit)
    );

    sso_route u_warn_route
    (
        .sel(warn_sel),
        .flag(warn_reg),
        .hit(warn_hit)
    );

    assign term_flags = run_hit | rdy_hit | warn_hit;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            TERM_N <= 3'h7;
        end
        else if (CE)
        begin
            TERM_N <= ~term_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // code outputs
    logic [2:0] code_flags;

    // an alarm code always wins; warnings show only when enabled
    always_comb
    begin
        code_flags = sso_pkg::CODE_NONE;
        if (ALARM_PRESENT)
        begin
            code_flags = ALARM_CODE;
        end
        else if (code_sel_reg && OVERLOAD_WARN)
        begin
            code_flags = sso_pkg::CODE_OVERLOAD;
        end
        else if (code_sel_reg && REGEN_WARN)
        begin
            code_flags = sso_pkg::CODE_REGEN;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            CODE_N <= 3'h7;
        end
        else if (CE)
        begin
            CODE_N <= ~code_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status display and speed monitor copies of the running flag
    logic [15:0] speed_mon_reg;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            STATUS_DISP_RUNNING <= 1'b0;
            SPEED_MON_RUNNING <= 1'b0;
            speed_mon_reg <= 16'h0000;
        end
        else if (CE)
        begin
            STATUS_DISP_RUNNING <= running_reg;
            SPEED_MON_RUNNING <= running_reg;
            speed_mon_reg <= MOTOR_SPEED;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, write one to clear, set beats clear
    logic running_d_reg;
    logic ready_d_reg;
    logic warn_d_reg;
    logic [2:0] ev;
    logic [2:0] clr;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            running_d_reg <= 1'b0;
            ready_d_reg <= 1'b0;
            warn_d_reg <= 1'b0;
        end
        else if (CE)
        begin
            running_d_reg <= running_reg;
            ready_d_reg <= ready_reg;
            warn_d_reg <= warn_reg;
        end
    end

    assign ev[sso_pkg::EV_RUN] = running_reg ^ running_d_reg;
    assign ev[sso_pkg::EV_RDY] = ready_reg ^ ready_d_reg;
    assign ev[sso_pkg::EV_WARN] = warn_reg && !warn_d_reg;
    assign clr = (WR && ADDR == sso_pkg::OFS_IRQ_STAT) ? WDATA[2:0] : 3'h0;
    assign irq_stat_next = (irq_stat_reg & ~clr) | ev;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            irq_stat_reg <= 3'h0;
            IRQ <= 1'b0;
        end
        else if (CE)
        begin
            irq_stat_reg <= irq_stat_next;
            IRQ <= |(irq_stat_next & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read, data in the cycle after the strobe only
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    always_comb
    begin
        status_word = 32'h0;
        status_word[sso_pkg::ST_RUN] = running_reg;
        status_word[sso_pkg::ST_RDY] = ready_reg;
        status_word[sso_pkg::ST_WARN] = warn_reg;
        status_word[sso_pkg::ST_CODE_LSB +: 3] = ~CODE_N;
        status_word[sso_pkg::ST_TERM_LSB +: 3] = ~TERM_N;
    end

    always_comb
    begin
        rd_mux = 32'h0;
        case (ADDR)
            sso_pkg::OFS_ROT_LEVEL: rd_mux = {18'h0, rot_level_reg};
            sso_pkg::OFS_OSEL_FIRST: rd_mux = {16'h0, osel_first_reg};
            sso_pkg::OFS_OSEL_SECOND: rd_mux = {16'h0, osel_second_reg};
            sso_pkg::OFS_CODE_SEL: rd_mux = {31'h0, code_sel_reg};
            sso_pkg::OFS_STATUS: rd_mux = status_word;
            sso_pkg::OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
            sso_pkg::OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
            sso_pkg::OFS_SPEED_MON:
                rd_mux = {15'h0, SPEED_MON_RUNNING, speed_mon_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            RDATA <= 32'h0;
        end
        else if (CE)
        begin
            RDATA <= RD ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    property p_run_set;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && above_level |=> running_reg;
    endproperty
    a_run_set: assert property (p_run_set)
        else $error("running flag missed speed above level");

    property p_run_clr;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && below_level ##1 CE |=> TERM_N[1] || run_sel != 4'h2
            || rdy_hit[1] || warn_hit[1] || $past(rdy_hit[1])
            || $past(warn_hit[1]);
    endproperty
    a_run_clr: assert property (p_run_clr)
        else $error("running terminal low with speed below level");

    property p_level_range;
        @(posedge SYS_CLK) disable iff (!RESETN)
        rot_level_reg >= sso_pkg::ROT_LEVEL_MIN
            && rot_level_reg <= sso_pkg::ROT_LEVEL_MAX;
    endproperty
    a_level_range: assert property (p_level_range)
        else $error("rotation level out of range");

    property p_mon_follow;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE |=> STATUS_DISP_RUNNING == $past(running_reg)
            && SPEED_MON_RUNNING == STATUS_DISP_RUNNING;
    endproperty
    a_mon_follow: assert property (p_mon_follow)
        else $error("status copies differ from running flag");

    property p_ready_block;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && (ALARM_PRESENT || !MAIN_POWER_ON) |=> !ready_reg;
    endproperty
    a_ready_block: assert property (p_ready_block)
        else $error("ready with alarm or power off");

    property p_ready_abs;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && ABS_ENCODER_FITTED && !ABS_DATA_SENT |=> !ready_reg;
    endproperty
    a_ready_abs: assert property (p_ready_abs)
        else $error("ready before absolute data sent");

    property p_warn;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && warn_cond |=> warn_reg;
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning flag missed its condition");

    property p_warn_term;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && warn_reg && warn_sel == 4'h3 |=> !TERM_N[2];
    endproperty
    a_warn_term: assert property (p_warn_term)
        else $error("warning not shown on its terminal");

    property p_or_term;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && ready_reg && rdy_sel == 4'h1 |=> !TERM_N[0];
    endproperty
    a_or_term: assert property (p_or_term)
        else $error("shared terminal not driven by ready");

    property p_code_alarm_only;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && !code_sel_reg && !ALARM_PRESENT |=> CODE_N == 3'h7;
    endproperty
    a_code_alarm_only: assert property (p_code_alarm_only)
        else $error("warning code shown while disabled");

    property p_code_ovl;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && code_sel_reg && !ALARM_PRESENT && OVERLOAD_WARN
            |=> CODE_N == 3'h6;
    endproperty
    a_code_ovl: assert property (p_code_ovl)
        else $error("overload code wrong");

    property p_code_regen;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CE && code_sel_reg && !ALARM_PRESENT && !OVERLOAD_WARN
            && REGEN_WARN |=> CODE_N == 3'h5;
    endproperty
    a_code_regen: assert property (p_code_regen)
        else $error("regenerative overload code wrong");
endmodule // sso_status_outputs
`default_nettype wire

// [core/sso_pkg.sv]
// shared constants of the servo status output block
package sso_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SPEED_W = 16;
    localparam int unsigned LEVEL_W = 14;
    // register byte offsets
    localparam logic [7:0] OFS_ROT_LEVEL = 8'h00;
    localparam logic [7:0] OFS_OSEL_FIRST = 8'h04;
    localparam logic [7:0] OFS_OSEL_SECOND = 8'h08;
    localparam logic [7:0] OFS_CODE_SEL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_SPEED_MON = 8'h1C;
    // rotation detection level limits and reset value, rpm
    localparam logic [13:0] ROT_LEVEL_MIN = 14'h0001;
    localparam logic [13:0] ROT_LEVEL_MAX = 14'h2710;
    localparam logic [13:0] ROT_LEVEL_RST = 14'h0014;
    // output selection reset values, one hex digit per signal
    localparam logic [15:0] OSEL_FIRST_RST = 16'h3211;
    localparam logic [15:0] OSEL_SECOND_RST = 16'h0000;
    localparam logic CODE_SEL_RST = 1'b0;
    // digit positions inside the selection words
    localparam int unsigned RUN_SEL_LSB = 8;
    localparam int unsigned RDY_SEL_LSB = 12;
    localparam int unsigned WARN_SEL_LSB = 12;
    localparam int unsigned SEL_W = 4;
    // status register bit positions
    localparam int unsigned ST_RUN = 0;
    localparam int unsigned ST_RDY = 1;
    localparam int unsigned ST_WARN = 2;
    localparam int unsigned ST_CODE_LSB = 4;
    localparam int unsigned ST_TERM_LSB = 8;
    // interrupt event bit positions
    localparam int unsigned EV_RUN = 0;
    localparam int unsigned EV_RDY = 1;
    localparam int unsigned EV_WARN = 2;
    localparam int unsigned EV_W = 3;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // speed monitor: running flag sits above the speed value
    localparam int unsigned MON_RUN = 16;
    // warning codes, active-high flags before output inversion
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_OVERLOAD = 3'h1;
    localparam logic [2:0] CODE_REGEN = 3'h2;
endpackage : sso_pkg

// [core/sso_route.sv]
// maps one indicator onto the terminal pairs by its selection digit
`timescale 1ns/1ps
`default_nettype none
module sso_route
(
    input wire logic [3:0] sel,
    input wire logic flag,
    output logic [2:0] hit
);
    // 0 leaves the indicator unassigned, 1..3 pick a terminal pair
    always_comb
    begin
        hit = 3'h0;
        case (sel)
            4'h1: hit = {2'h0, flag};
            4'h2: hit = {1'h0, flag, 1'h0};
            4'h3: hit = {flag, 2'h0};
            default: hit = 3'h0;
        endcase
    end
endmodule // sso_route
`default_nettype wire

// [test/sso_host_model.sv]
// host controller model: drives encoder sense, watches the ready pair
`timescale 1ns/1ps
`default_nettype none
module sso_host_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hold_sense,
    input wire logic [2:0] term_n,
    output logic sense,
    output logic servo_on_req
);
    ////////////////////////////////////////////////////////////////////////
    // sense pin is held high only while the bench asks for it
    always_ff @(posedge clk)
    begin
        sense <= resetn & hold_sense;
    end
    ////////////////////////////////////////////////////////////////////////
    // servo-on is requested only once the ready pair is closed
    always_ff @(posedge clk)
    begin
        servo_on_req <= resetn & ~term_n[2];
    end
endmodule // sso_host_model
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench of the servo status outputs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rstn, wr, rd, sense, hold, srv, ce;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d, v;
    logic [15:0] speed;
    logic alarm, pwr, absf, sent, ov, rg, run_e, csel;
    logic [2:0] acode, term_n, code_n;
    logic disp_run, mon_run, irq;
    logic [13:0] lvl;
    logic [3:0] dr, dy, dw;
    logic [31:0] lv_tab [5] = '{32'h0, 32'h2711, 32'h2710, 32'h4001, 32'h1};
    int miscompares, tests_run, seed;
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    sso_status_outputs i_sso_status_outputs
    (
        .SYS_CLK(clk), .RESETN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .MOTOR_SPEED(speed),
        .ALARM_PRESENT(alarm), .ALARM_CODE(acode), .MAIN_POWER_ON(pwr),
        .ABS_ENCODER_FITTED(absf), .ABS_DATA_SENT(sent),
        .ENCODER_SENSE_INPUT(sense), .OVERLOAD_WARN(ov), .REGEN_WARN(rg),
        .TERM_N(term_n), .CODE_N(code_n), .STATUS_DISP_RUNNING(disp_run),
        .SPEED_MON_RUNNING(mon_run), .IRQ(irq)
    );
    sso_host_model i_sso_host_model
    (
        .clk(clk), .resetn(rstn), .hold_sense(hold), .term_n(term_n),
        .sense(sense), .servo_on_req(srv)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // expected values worked out from the inputs the bench applied
    function automatic logic [2:0] hit(input logic [3:0] dg, input logic f);
        hit = (f && dg >= 4'h1 && dg <= 4'h3) ? 3'h1 << (dg - 4'h1) : 3'h0;
    endfunction
    function automatic logic step(input logic cur, input logic [15:0] s,
                                  input logic [13:0] l);
        step = (s > {2'h0, l}) ? 1'b1 : ((s < {2'h0, l}) ? 1'b0 : cur);
    endfunction
    function automatic logic [2:0] code_exp();
        if (alarm)
            code_exp = ~acode;
        else if (csel && ov)
            code_exp = 3'h6;
        else if (csel && rg)
            code_exp = 3'h5;
        else
            code_exp = 3'h7;
    endfunction
    task automatic check_all();
        logic rdy, wn;
        logic [2:0] tf;
        rdy = !alarm && pwr && (!absf || (hold && sent));
        wn = ov | rg;
        tf = hit(dr, run_e) | hit(dy, rdy) | hit(dw, wn);
        chk("term_n", {29'h0, term_n}, {29'h0, ~tf});
        chk("servo_on", {31'h0, srv}, {31'h0, tf[2]});
        chk("code_n", {29'h0, code_n}, {29'h0, code_exp()});
        chk("disp_run", {31'h0, disp_run}, {31'h0, run_e});
        chk("mon_run", {31'h0, mon_run}, {31'h0, run_e});
        rd_reg(sso_pkg::OFS_STATUS);
        chk("status", d, {21'h0, tf, 1'b0, ~code_exp(), 1'b0, wn, rdy,
            run_e});
        rd_reg(sso_pkg::OFS_SPEED_MON);
        chk("speed_mon", d, {15'h0, run_e, speed});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("[ERR] watchdog expected done seen hang");
        conclude();
    end
    initial
    begin
        seed = 32'h788B;
        miscompares = 0;
        tests_run = 0;
        {rstn, wr, rd, addr, wdata, speed, acode} = '0;
        {alarm, pwr, absf, sent, ov, rg, hold, run_e, csel} = '0;
        ce = 1'b1;
        lvl = sso_pkg::ROT_LEVEL_RST;
        dr = 4'h2;
        dy = 4'h3;
        dw = 4'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(sso_pkg::OFS_ROT_LEVEL);
        chk("level_rst", d, 32'h14);
        rd_reg(sso_pkg::OFS_OSEL_FIRST);
        chk("osel1_rst", d, 32'h3211);
        rd_reg(sso_pkg::OFS_OSEL_SECOND);
        chk("osel2_rst", d, 32'h0);
        rd_reg(sso_pkg::OFS_CODE_SEL);
        chk("csel_rst", d, 32'h0);
        rd_reg(8'h40);
        chk("unmapped", d, 32'h0);
        check_all();
        foreach (lv_tab[i])
        begin
            wr_reg(sso_pkg::OFS_ROT_LEVEL, lv_tab[i]);
            if (lv_tab[i] >= 32'h1 && lv_tab[i] <= 32'h2710)
                lvl = lv_tab[i][13:0];
            rd_reg(sso_pkg::OFS_ROT_LEVEL);
            chk("level", d, {18'h0, lvl});
        end
        for (int i = 0; i < 40; i++)
        begin
            v = $random(seed);
            @(posedge clk);
            speed <= {7'h0, v[24:16]};
            {alarm, absf, acode} <= {v[0], v[3], v[14:12]};
            {pwr, sent, hold} <= {v[1] | v[2], v[4] | v[5], v[6] | v[7]};
            {ov, rg} <= {v[8] & v[9], v[10] & v[11]};
            settle(2);
            run_e = step(run_e, speed, lvl);
            v = $random(seed);
            d = (i % 5 == 1) ? {16'h0, speed} : {23'h0, v[8:0]};
            if (i % 7 == 0)
                d = 32'h0;
            wr_reg(sso_pkg::OFS_ROT_LEVEL, d);
            if (d >= 32'h1 && d <= 32'h2710)
                lvl = d[13:0];
            dr = (i == 0) ? 4'h1 : {1'b0, v[11:9]};
            dy = (i == 0) ? 4'h1 : {1'b0, v[14:12]};
            dw = (i == 0) ? 4'h1 : {1'b0, v[17:15]};
            csel = v[18];
            wr_reg(sso_pkg::OFS_OSEL_FIRST, {16'h0, dy, dr, 8'h11});
            wr_reg(sso_pkg::OFS_OSEL_SECOND, {16'h0, dw, 12'h0});
            wr_reg(sso_pkg::OFS_CODE_SEL, {31'h0, csel});
            settle(6);
            run_e = step(run_e, speed, lvl);
            check_all();
            chk("irq_masked", {31'h0, irq}, 32'h0);
        end
        @(posedge clk);
        {alarm, ov, rg, speed} <= '0;
        settle(6);
        run_e = 1'b0;
        wr_reg(sso_pkg::OFS_IRQ_STAT, 32'h7);
        rd_reg(sso_pkg::OFS_IRQ_STAT);
        chk("irq_stat_clr", d, 32'h0);
        wr_reg(sso_pkg::OFS_IRQ_MASK, 32'h4);
        @(posedge clk);
        ov <= 1'b1;
        settle(4);
        chk("irq_warn", {31'h0, irq}, 32'h1);
        rd_reg(sso_pkg::OFS_IRQ_STAT);
        chk("irq_stat_warn", d, 32'h4);
        wr_reg(sso_pkg::OFS_IRQ_MASK, 32'h0);
        settle(2);
        chk("irq_off", {31'h0, irq}, 32'h0);
        wr_reg(sso_pkg::OFS_IRQ_MASK, 32'h4);
        wr_reg(sso_pkg::OFS_IRQ_STAT, 32'h4);
        settle(2);
        chk("irq_w1c", {31'h0, irq}, 32'h0);
        wr_reg(sso_pkg::OFS_IRQ_MASK, 32'h1);
        // clock enable low must freeze the running flag and its event
        @(posedge clk);
        ce <= 1'b0;
        speed <= {2'h0, lvl} + 16'h1;
        settle(4);
        chk("frozen_run", {31'h0, disp_run}, 32'h0);
        chk("frozen_irq", {31'h0, irq}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        settle(4);
        chk("irq_run", {31'h0, irq}, 32'h1);
        run_e = 1'b1;
        check_all();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
